/* sim/dsbwa_access_monitor.sv */
/*
  Port-level checker for the data-space access unit.
  Assumes it is bound to dsbwa_access and sees only its ports.
*/
`timescale 1ns/10ps
module dsbwa_access_monitor (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic byte_i,
  input wire logic word_only_i,
  input wire logic [1:0] mode_i,
  input wire logic [12:0] near_field_i,
  input wire logic [15:0] move_field_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic addr_err_o,
  input wire logic [15:0] effective_address_o,
  input wire logic sfr_hit_o,
  input wire logic [5:0] sfr_region_o,
  input wire logic near_hit_o
);
  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  logic word_req;
  assign word_req = req_i && (!byte_i || word_only_i);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  AST_ODD_ERR: assert property (word_req && mode_i == 2'h2 && move_field_i[0] |=> addr_err_o)
    else $error("odd word access gave no address error");
  AST_BYTE_OK: assert property (req_i && byte_i && !word_only_i |=> !addr_err_o)
    else $error("byte access raised an address error");
  AST_ERR_CAUSE: assert property (addr_err_o |-> $past(word_req) && effective_address_o[0])
    else $error("address error without a word request");
  AST_RD_VALID: assert property (req_i && !write_i |=> rvalid_o)
    else $error("read did not complete");
  AST_RV_CAUSE: assert property (rvalid_o |-> $past(req_i && !write_i))
    else $error("read valid without a read");
  AST_MOVE_EA: assert property (req_i && mode_i == 2'h2 |=> effective_address_o == $past(move_field_i))
    else $error("move address not taken whole");
  AST_NEAR_EA: assert property (req_i && mode_i == 2'h1 |=> effective_address_o == {3'h0, $past(near_field_i)})
    else $error("near address not zero extended");
  AST_DECODE: assert property (req_i |=> near_hit_o == (effective_address_o <= 16'h1FFF) && sfr_hit_o == (effective_address_o <= 16'h07FF) && sfr_region_o == effective_address_o[10:5])
    else $error("space decode wrong");
  AST_BYTE_RD: assert property (req_i && !write_i && byte_i && !word_only_i |=> rdata_o[15:8] == 8'h00)
    else $error("byte read upper lane not clear");
endmodule : dsbwa_access_monitor

bind dsbwa_access dsbwa_access_monitor i_dsbwa_access_monitor (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .req_i(req_i), .write_i(write_i), .byte_i(byte_i),
  .word_only_i(word_only_i), .mode_i(mode_i), .near_field_i(near_field_i),
  .move_field_i(move_field_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .addr_err_o(addr_err_o), .effective_address_o(effective_address_o),
  .sfr_hit_o(sfr_hit_o), .sfr_region_o(sfr_region_o), .near_hit_o(near_hit_o));

/* sim/dsbwa_access_tb_top.sv */
/*
  Self-checking bench for the data-space access unit.
  Assumes a 20 MHz clock and the behavioural requester model.
*/
`timescale 1ns/10ps
module dsbwa_access_tb_top;
  // ----------------------------------------
  // Harness and scenarios.
  // ----------------------------------------
  logic clock_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic word_only = 1'h0;
  logic post_inc = 1'h0;
  logic [3:0] src = 4'h0;
  logic [3:0] dest = 4'h0;
  logic [2:0] reg_op = 3'h0;
  logic req, wr, byt, rvalid, aerr, sfr, sfr_ok, nhit;
  logic [1:0] mode;
  logic [12:0] near;
  logic [5:0] region;
  logic [15:0] move, wdata, rdata, ea, view;
  int error_cnt = 0;
  int compares = 0;

  always #25 clock_i = ~clock_i;

  dsbwa_core_model i_dsbwa_core_model (.clock_i(clock_i), .req_o(req), .write_o(wr),
    .byte_o(byt), .mode_o(mode), .near_o(near), .move_o(move), .wdata_o(wdata));

  dsbwa_access i_dsbwa_access (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .write_i(wr), .byte_i(byt), .word_only_i(word_only), .post_inc_i(post_inc),
    .mode_i(mode), .source_working_register_i(src), .near_field_i(near),
    .move_field_i(move), .wdata_i(wdata), .reg_op_i(reg_op), .dest_reg_i(dest),
    .rdata_o(rdata), .rvalid_o(rvalid), .addr_err_o(aerr), .effective_address_o(ea),
    .sfr_hit_o(sfr), .sfr_region_valid_o(sfr_ok), .sfr_region_o(region),
    .near_hit_o(nhit), .wreg_view_o(view));

  task automatic chk(input string n, input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic rq(input logic w, b, input logic [1:0] m, input logic [15:0] a, d);
    i_dsbwa_core_model.xfer(1'h1, w, b, m, a, d);
  endtask : rq

  // Idle cycle; wdata carries load data and byte size is flagged so a load
  // takes only the low byte.
  task automatic rop(input logic [2:0] op, input logic [3:0] s, dd, input logic [15:0] d);
    reg_op = op;
    src = s;
    dest = dd;
    i_dsbwa_core_model.xfer(1'h0, 1'h0, 1'h1, 2'h0, 16'h0, d);
    reg_op = 3'h0;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : rop

  task automatic t_lanes;
    rq(1'h1, 1'h0, 2'h2, 16'h0100, 16'h1234);
    rq(1'h1, 1'h1, 2'h2, 16'h0101, 16'h00AB);
    rq(1'h0, 1'h0, 2'h2, 16'h0100, 16'h0);
    chk("word", rdata, 16'hAB34);
    rq(1'h0, 1'h1, 2'h2, 16'h0101, 16'h0);
    chk("hi byte", rdata, 16'h00AB);
    rq(1'h0, 1'h1, 2'h2, 16'h0100, 16'h0);
    chk("lo byte", rdata, 16'h0034);
  endtask : t_lanes

  task automatic t_mis;
    rq(1'h1, 1'h0, 2'h2, 16'h0102, 16'h5555);
    chk("err even", {15'h0, aerr}, 16'h0);
    rq(1'h1, 1'h0, 2'h2, 16'h0103, 16'hFFFF);
    chk("err odd", {15'h0, aerr}, 16'h1);
    rq(1'h0, 1'h0, 2'h2, 16'h0102, 16'h0);
    chk("kept", rdata, 16'h5555);
    rq(1'h0, 1'h0, 2'h2, 16'h0101, 16'h0);
    chk("odd rd", {14'h0, rvalid, aerr}, 16'h3);
    word_only = 1'h1;
    rq(1'h0, 1'h1, 2'h2, 16'h0103, 16'h0);
    chk("word only", {14'h0, rvalid, aerr}, 16'h3);
    word_only = 1'h0;
    rop(3'h0, 4'h0, 4'h0, 16'h0);
    chk("pulse", {14'h0, rvalid, aerr}, 16'h0);
  endtask : t_mis

  task automatic t_dec;
    logic [15:0] av [6];
    av = '{16'h0000, 16'h07FF, 16'h0800, 16'h1FFF, 16'h2000, 16'hFFFE};
    for (int i = 0; i < 6; i++) begin
      rq(1'h0, 1'h1, (av[i] > 16'h1FFF) ? 2'h2 : 2'h1, av[i], 16'h0);
      chk("ea", ea, av[i]);
      chk("hits", {13'h0, nhit, sfr, sfr_ok},
          {13'h0, av[i] <= 16'h1FFF, av[i] <= 16'h07FF, av[i] <= 16'h07FF});
      chk("region", {10'h0, region}, {10'h0, av[i][10:5]});
    end
  endtask : t_dec

  task automatic t_regs;
    rop(dsbwa_pkg::DSBWA_OP_LOAD, 4'h0, 4'h1, 16'hAA85);
    chk("load", view, 16'h0085);
    rop(dsbwa_pkg::DSBWA_OP_SIGN_EXT, 4'h1, 4'h2, 16'h0);
    chk("sign", view, 16'hFF85);
    rop(dsbwa_pkg::DSBWA_OP_LOAD, 4'h0, 4'h2, 16'h0012);
    chk("keep hi", view, 16'hFF12);
    rop(dsbwa_pkg::DSBWA_OP_ZERO_EXT, 4'h2, 4'h2, 16'h0);
    chk("zero", view, 16'h0012);
  endtask : t_regs

  task automatic t_pinc;
    post_inc = 1'h1;
    src = 4'h4;
    dest = 4'h4;
    rq(1'h0, 1'h0, 2'h0, 16'h0, 16'h0);
    chk("ea w", ea, 16'h0000);
    rq(1'h0, 1'h1, 2'h0, 16'h0, 16'h0);
    chk("ea b", ea, 16'h0002);
    post_inc = 1'h0;
    i_dsbwa_core_model.xfer(1'h0, 1'h0, 1'h0, 2'h0, 16'h0, 16'h0);
    chk("step", view, 16'h0003);
  endtask : t_pinc

  task automatic tally_and_finish;
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 1'h0;
    @(negedge clock_i);
    t_lanes;
    t_mis;
    t_dec;
    t_regs;
    t_pinc;
    tally_and_finish;
  end
endmodule : dsbwa_access_tb_top

/* sim/dsbwa_core_model.sv */
/*
  Behavioural requester standing in for the core's execution unit.
  Assumes xfer is entered just after a falling clock edge.
*/
`timescale 1ns/10ps
module dsbwa_core_model (
  input wire logic clock_i,
  output logic req_o,
  output logic write_o,
  output logic byte_o,
  output logic [1:0] mode_o,
  output logic [12:0] near_o,
  output logic [15:0] move_o,
  output logic [15:0] wdata_o
);
  // ----------------------------------------
  // Request driver.
  // ----------------------------------------
  initial begin
    req_o = 1'h0;
    write_o = 1'h0;
    byte_o = 1'h0;
    mode_o = 2'h0;
    near_o = 13'h0;
    move_o = 16'h0;
    wdata_o = 16'h0;
  end

  // The request is held to the next falling edge so back-to-back calls
  // never drive one signal twice in a time step. Odd word requests are
  // only issued when a test asks for the fault.
  task automatic xfer(input logic r, w, b, input logic [1:0] m,
                      input logic [15:0] a, d);
    req_o = r;
    write_o = w;
    byte_o = b;
    mode_o = m;
    near_o = a[12:0];
    move_o = a;
    wdata_o = d;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : xfer
endmodule : dsbwa_core_model

/* src/dsbwa_access.sv */
/*
  Data-space access unit: address generation, lane steering, alignment
  trap, near/SFR decode and working-register byte handling.
  Assumes one request per cycle from the execution unit on clock_i.
*/
`timescale 1ns/10ps
module dsbwa_access (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic byte_i,
  input wire logic word_only_i,
  input wire logic post_inc_i,
  input wire logic [1:0] mode_i,
  input wire logic [dsbwa_pkg::WREG_IDX_W-1:0] source_working_register_i,
  input wire logic [dsbwa_pkg::NEAR_W-1:0] near_field_i,
  input wire logic [dsbwa_pkg::ADDR_W-1:0] move_field_i,
  input wire logic [dsbwa_pkg::DATA_W-1:0] wdata_i,
  input wire logic [2:0] reg_op_i,
  input wire logic [dsbwa_pkg::WREG_IDX_W-1:0] dest_reg_i,
  output logic [dsbwa_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic addr_err_o,
  output logic [dsbwa_pkg::ADDR_W-1:0] effective_address_o,
  output logic sfr_hit_o,
  output logic sfr_region_valid_o,
  output logic [dsbwa_pkg::REGION_W:0] sfr_region_o,
  output logic near_hit_o,
  output logic [dsbwa_pkg::DATA_W-1:0] wreg_view_o
);
  // Top address bit of the register-space region index.
  localparam int unsigned SFR_TOP = dsbwa_pkg::REGION_W + $clog2(dsbwa_pkg::SFR_REGIONS) - 1;

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------
  function automatic logic [dsbwa_pkg::DATA_W-1:0] merge_byte(
    input logic [dsbwa_pkg::DATA_W-1:0] old_w,
    input logic [dsbwa_pkg::BYTE_W-1:0] b
  );
    merge_byte = {old_w[dsbwa_pkg::DATA_W-1:dsbwa_pkg::BYTE_W], b};
  endfunction : merge_byte

  function automatic logic [dsbwa_pkg::DATA_W-1:0] sign_ext(
    input logic [dsbwa_pkg::BYTE_W-1:0] b
  );
    sign_ext = {(b[dsbwa_pkg::BYTE_W-1] ? dsbwa_pkg::ONES_BYTE : dsbwa_pkg::ZERO_BYTE),
      b};
  endfunction : sign_ext

  function automatic logic [dsbwa_pkg::DATA_W-1:0] zero_ext(
    input logic [dsbwa_pkg::BYTE_W-1:0] b
  );
    zero_ext = {dsbwa_pkg::ZERO_BYTE, b};
  endfunction : zero_ext

  // A byte read still fetches the whole word; the low address bit picks
  // which lane lands on the low byte of the data path.
  function automatic logic [dsbwa_pkg::BYTE_W-1:0] pick_byte(
    input logic [dsbwa_pkg::DATA_W-1:0] w,
    input logic odd
  );
    pick_byte = odd ? w[dsbwa_pkg::DATA_W-1:dsbwa_pkg::BYTE_W] :
      w[dsbwa_pkg::BYTE_W-1:0];
  endfunction : pick_byte

  function automatic logic [dsbwa_pkg::ADDR_W-1:0] ea_step(
    input logic byte_op
  );
    ea_step = byte_op ? dsbwa_pkg::STEP_BYTE : dsbwa_pkg::STEP_WORD;
  endfunction : ea_step

  function automatic logic in_near(
    input logic [dsbwa_pkg::ADDR_W-1:0] a
  );
    in_near = (a <= dsbwa_pkg::NEAR_LAST);
  endfunction : in_near

  function automatic logic in_sfr(
    input logic [dsbwa_pkg::ADDR_W-1:0] a
  );
    in_sfr = (a <= dsbwa_pkg::SFR_LAST);
  endfunction : in_sfr

  // The index is taken for any address; only sfr_region_valid_o qualifies it with in_sfr, sfr_region_o does not.
  function automatic logic [dsbwa_pkg::REGION_W:0] region_of(
    input logic [dsbwa_pkg::ADDR_W-1:0] a
  );
    region_of = a[SFR_TOP:dsbwa_pkg::REGION_W];
  endfunction : region_of

  // ---------------------------------------------------------------------
  // Working registers
  // ---------------------------------------------------------------------
  logic [dsbwa_pkg::DATA_W-1:0] wreg [dsbwa_pkg::NUM_WREG];
  logic [dsbwa_pkg::DATA_W-1:0] base_reg;
  logic [dsbwa_pkg::ADDR_W-1:0] ea;
  logic odd_word;
  logic legal_size;
  logic [dsbwa_pkg::DATA_W-1:0] mem_rdata;
  logic [dsbwa_pkg::BYTE_W-1:0] sel_byte;
  logic mem_wr_lo;
  logic mem_wr_hi;
  logic [dsbwa_pkg::DATA_W-1:0] lane_wdata;

  assign base_reg = wreg[source_working_register_i];

  logic [dsbwa_pkg::BYTE_W-1:0] src_byte;
  assign src_byte = base_reg[dsbwa_pkg::BYTE_W-1:0];

  // ---------------------------------------------------------------------
  // Effective address
  // ---------------------------------------------------------------------
  always_comb begin
    case (mode_i)
      dsbwa_pkg::DSBWA_AM_NEAR: begin
        ea = {{(dsbwa_pkg::ADDR_W - dsbwa_pkg::NEAR_W){1'b0}}, near_field_i};
      end
      dsbwa_pkg::DSBWA_AM_MOVE: begin
        ea = move_field_i;
      end
      default: begin
        ea = base_reg;
      end
    endcase
  end

  // Word-only instructions must not be issued as byte accesses; a byte
  // request on one is forced to word size so alignment is still checked.
  assign legal_size = byte_i && !word_only_i;
  assign odd_word = !legal_size && ea[0];

  // ---------------------------------------------------------------------
  // Lane steering
  // ---------------------------------------------------------------------
  // A faulting write still runs but both strobes stay low.
  always_comb begin
    mem_wr_lo = 1'b0;
    mem_wr_hi = 1'b0;
    lane_wdata = wdata_i;
    if (req_i && write_i && !odd_word) begin
      if (legal_size) begin
        lane_wdata = {wdata_i[dsbwa_pkg::BYTE_W-1:0], wdata_i[dsbwa_pkg::BYTE_W-1:0]};
        mem_wr_lo = !ea[0];
        mem_wr_hi = ea[0];
      end else begin
        mem_wr_lo = 1'b1;
        mem_wr_hi = 1'b1;
      end
    end
  end

  dsbwa_lane_mem u_mem (
    .clock_i(clock_i),
    .word_idx_i(ea[dsbwa_pkg::MEM_IDX_W:1]),
    .wr_lo_i(mem_wr_lo),
    .wr_hi_i(mem_wr_hi),
    .wdata_i(lane_wdata),
    .rdata_o(mem_rdata)
  );

  assign sel_byte = pick_byte(mem_rdata, ea[0]);

  // ---------------------------------------------------------------------
  // Read data and trap
  // ---------------------------------------------------------------------
  // A faulting read still returns data so the instruction completes; the
  // trap pulse lets the exception unit vector afterwards.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i && !write_i;
    end
  end

  // Read data holds between reads so a slow consumer still sees it.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_o <= dsbwa_pkg::ZERO_WORD;
    end else if (req_i && !write_i) begin
      rdata_o <= legal_size ? zero_ext(sel_byte) : mem_rdata;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      addr_err_o <= 1'b0;
    end else begin
      addr_err_o <= req_i && odd_word;
    end
  end

  // ---------------------------------------------------------------------
  // Address decode and effective address report
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      effective_address_o <= dsbwa_pkg::ZERO_WORD;
    end else if (req_i) begin
      effective_address_o <= ea;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      near_hit_o <= 1'b0;
    end else if (req_i) begin
      near_hit_o <= in_near(ea);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sfr_hit_o <= 1'b0;
    end else if (req_i) begin
      sfr_hit_o <= in_sfr(ea);
    end
  end

  // A region outside the implemented map reads as not valid even inside
  // register space, so a stray pointer never claims a missing block.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sfr_region_o <= '0;
      sfr_region_valid_o <= 1'b0;
    end else if (req_i) begin
      sfr_region_o <= region_of(ea);
      sfr_region_valid_o <= in_sfr(ea) && dsbwa_pkg::SFR_IMPL_MAP[region_of(ea)];
    end
  end

  // ---------------------------------------------------------------------
  // Working register update
  // ---------------------------------------------------------------------
  // Post-increment wins over a load to the same register in one cycle.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < dsbwa_pkg::NUM_WREG; i++) begin
        wreg[i] <= dsbwa_pkg::ZERO_WORD;
      end
    end else begin
      case (reg_op_i)
        dsbwa_pkg::DSBWA_OP_LOAD: begin
          if (legal_size) begin
            wreg[dest_reg_i] <= merge_byte(wreg[dest_reg_i],
              wdata_i[dsbwa_pkg::BYTE_W-1:0]);
          end else begin
            wreg[dest_reg_i] <= wdata_i;
          end
        end
        dsbwa_pkg::DSBWA_OP_SIGN_EXT: begin
          wreg[dest_reg_i] <= sign_ext(src_byte);
        end
        dsbwa_pkg::DSBWA_OP_ZERO_EXT: begin
          wreg[dest_reg_i] <= zero_ext(src_byte);
        end
        default: begin
        end
      endcase
      if (req_i && post_inc_i && mode_i == dsbwa_pkg::DSBWA_AM_INDIRECT) begin
        wreg[source_working_register_i] <= base_reg + ea_step(legal_size);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wreg_view_o <= dsbwa_pkg::ZERO_WORD;
    end else begin
      wreg_view_o <= wreg[dest_reg_i];
    end
  end
endmodule : dsbwa_access

/* src/dsbwa_lane_mem.sv */
/*
  Byte-lane data memory: two byte-wide arrays sharing one word decode.
  Assumes the caller supplies the word index and per-lane write strobes.
*/
`timescale 1ns/10ps
module dsbwa_lane_mem (
  input wire logic clock_i,
  input wire logic [dsbwa_pkg::MEM_IDX_W-1:0] word_idx_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [dsbwa_pkg::DATA_W-1:0] wdata_i,
  output logic [dsbwa_pkg::DATA_W-1:0] rdata_o
);
  logic [dsbwa_pkg::BYTE_W-1:0] lane_lo [dsbwa_pkg::MEM_WORDS];
  logic [dsbwa_pkg::BYTE_W-1:0] lane_hi [dsbwa_pkg::MEM_WORDS];

  // Each lane has its own strobe so a byte write leaves its partner alone.
  always_ff @(posedge clock_i) begin
    if (wr_lo_i) begin
      lane_lo[word_idx_i] <= wdata_i[dsbwa_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_hi_i) begin
      lane_hi[word_idx_i] <= wdata_i[dsbwa_pkg::DATA_W-1:dsbwa_pkg::BYTE_W];
    end
  end

  // Both lanes read the whole word together.
  assign rdata_o = {lane_hi[word_idx_i], lane_lo[word_idx_i]};
endmodule : dsbwa_lane_mem

/* src/dsbwa_pkg.sv */
/*
  Constants for the data-space byte/word access block.
  Assumes a 16-bit core with a byte-addressed 64 KB data space.
*/
package dsbwa_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NEAR_W = 13;
  localparam int unsigned REGION_W = 5;
  localparam int unsigned SFR_REGIONS = 64;
  localparam int unsigned NUM_WREG = 16;
  localparam int unsigned WREG_IDX_W = 4;
  localparam int unsigned MEM_WORDS = 256;
  localparam int unsigned MEM_IDX_W = 8;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;
  localparam logic [ADDR_W-1:0] SFR_LAST = 16'h07FF;
  localparam logic [ADDR_W-1:0] NEAR_LAST = 16'h1FFF;
  localparam logic [SFR_REGIONS-1:0] SFR_IMPL_MAP = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [BYTE_W-1:0] ONES_BYTE = 8'hFF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // Addressing modes for the data operand.
  typedef enum logic [1:0] {
    DSBWA_AM_INDIRECT = 2'h0,
    DSBWA_AM_NEAR = 2'h1,
    DSBWA_AM_MOVE = 2'h2
  } dsbwa_mode_e;

  // Register-side operations.
  typedef enum logic [2:0] {
    DSBWA_OP_NONE = 3'h0,
    DSBWA_OP_LOAD = 3'h1,
    DSBWA_OP_SIGN_EXT = 3'h2,
    DSBWA_OP_ZERO_EXT = 3'h4
  } dsbwa_op_e;
endpackage : dsbwa_pkg
